// *** logic/multifunction_pin_mux.v ***
// multifunction pin multiplexer with apb register access
`timescale 1ns/1ps
`include "pin_mux_consts.vh"

// ==========================================

module multifunction_pin_mux (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// internal sources routed out to the pins
	input  wire        clock_output,
	input  wire        interrupt_out_a,
	input  wire        interrupt_out_b,
	input  wire        rec_word_clk,
	input  wire        sec_bit_clk,
	input  wire        sec_word_clk,
	input  wire        dmic_clk,
	input  wire        primary_data_out,
	// general pin
	input  wire        multi_pin_five_i,
	output reg         multi_pin_five_o,
	output reg         multi_pin_five_oe,
	output wire        multi_pin_five_ie,
	output wire        multi_pin_five_route,
	// data-out pin
	output reg         multi_pin_two_o,
	output reg         multi_pin_two_oe,
	output wire        multi_pin_two_keep_en,
	// data-in pin
	input  wire        multi_pin_one_i,
	output wire        multi_pin_one_ie,
	output wire        multi_pin_one_route
);

	// ==========================================
	// helpers

	// register index from the byte address; misaligned words miss every register
	function hit;
		input [11:0] addr;
		input [7:0]  idx;
		begin
			hit = (addr[1:0] == 2'h0) && (addr[11:`ADDR_LSB] == {2'h0, idx});
		end
	endfunction

	function known;
		input [11:0] addr;
		begin
			known = hit(addr, `RSVD_A_IDX) || hit(addr, `RSVD_B_IDX) ||
				hit(addr, `GEN_CTRL_IDX) || hit(addr, `DOUT_CTRL_IDX) ||
				hit(addr, `DIN_CTRL_IDX);
		end
	endfunction

	// general pin decodes, shared by the input buffer, the route and the status flop
	function gen_is_route;
		input [3:0] fn;
		begin
			gen_is_route = (fn == `GEN_ROUTE_IN);
		end
	endfunction

	function gen_is_gp_in;
		input [3:0] fn;
		begin
			gen_is_gp_in = (fn == `GEN_GP_IN);
		end
	endfunction

	function gen_in_on;
		input [3:0] fn;
		begin
			gen_in_on = gen_is_route(fn) || gen_is_gp_in(fn);
		end
	endfunction

	// data-in decodes; the unused code 11 falls out as off
	function din_is_route;
		input [1:0] fn;
		begin
			din_is_route = (fn == `DIN_ROUTE_IN);
		end
	endfunction

	function din_is_gp_in;
		input [1:0] fn;
		begin
			din_is_gp_in = (fn == `DIN_GP_IN);
		end
	endfunction

	function din_in_on;
		input [1:0] fn;
		begin
			din_in_on = din_is_route(fn) || din_is_gp_in(fn);
		end
	endfunction

	// read images: reserved bits are built as zero, never stored
	function [7:0] gen_image;
		input [3:0] fn;
		input       samp;
		input       lvl;
		begin
			gen_image = 8'h00;
			gen_image[`GEN_FN_HI:`GEN_FN_LO] = fn;
			gen_image[`GEN_STAT_BIT] = samp;
			gen_image[`GEN_LVL_BIT] = lvl;
		end
	endfunction

	function [7:0] dout_image;
		input       keep;
		input [2:0] fn;
		input       lvl;
		begin
			dout_image = 8'h00;
			dout_image[`DOUT_KEEP_BIT] = keep;
			dout_image[`DOUT_FN_HI:`DOUT_FN_LO] = fn;
			dout_image[`DOUT_LVL_BIT] = lvl;
		end
	endfunction

	function [7:0] din_image;
		input [1:0] fn;
		input       samp;
		begin
			din_image = 8'h00;
			din_image[`DIN_FN_HI:`DIN_FN_LO] = fn;
			din_image[`DIN_STAT_BIT] = samp;
		end
	endfunction

	// ==========================================
	// control state

	reg  [3:0] gen_fn_r;
	reg        gen_lvl_r;
	reg        gen_samp_r;
	reg        dout_keep_r;
	reg  [2:0] dout_fn_r;
	reg        dout_lvl_r;
	reg  [1:0] din_fn_r;
	reg        din_samp_r;
	reg  [7:0] gen_rd;
	reg  [7:0] dout_rd;
	reg  [7:0] din_rd;
	reg  [7:0] rd_nxt;

	wire setup;
	wire wr_en;

	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite;
	// zero wait states: read data is already latched at setup
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !known(paddr);

	// ==========================================
	// register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_fn_r    <= `GEN_FN_RST;
			gen_lvl_r   <= `GEN_LVL_RST;
			dout_keep_r <= `DOUT_KEEP_RST;
			dout_fn_r   <= `DOUT_FN_RST;
			dout_lvl_r  <= `DOUT_LVL_RST;
			din_fn_r    <= `DIN_FN_RST;
		end else if (wr_en) begin
			// reserved fields and registers take no write
			if (hit(paddr, `GEN_CTRL_IDX)) begin
				gen_fn_r  <= pwdata[`GEN_FN_HI:`GEN_FN_LO];
				gen_lvl_r <= pwdata[`GEN_LVL_BIT];
			end
			if (hit(paddr, `DOUT_CTRL_IDX)) begin
				dout_keep_r <= pwdata[`DOUT_KEEP_BIT];
				dout_fn_r   <= pwdata[`DOUT_FN_HI:`DOUT_FN_LO];
				dout_lvl_r  <= pwdata[`DOUT_LVL_BIT];
			end
			if (hit(paddr, `DIN_CTRL_IDX)) begin
				din_fn_r <= pwdata[`DIN_FN_HI:`DIN_FN_LO];
			end
		end
	end

	// ==========================================
	// input pin sampling
	// a disabled input buffer reads back as zero rather than a floating level
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_samp_r <= 1'b0;
			din_samp_r <= 1'b0;
		end else begin
			gen_samp_r <= multi_pin_five_i && gen_is_gp_in(gen_fn_r);
			din_samp_r <= multi_pin_one_i && din_is_gp_in(din_fn_r);
		end
	end

	// ==========================================
	// read path
	always @* begin
		gen_rd = gen_image(gen_fn_r, gen_samp_r, gen_lvl_r);
		dout_rd = dout_image(dout_keep_r, dout_fn_r, dout_lvl_r);
		din_rd = din_image(din_fn_r, din_samp_r);
		rd_nxt = 8'h00;
		if (hit(paddr, `GEN_CTRL_IDX)) begin
			rd_nxt = gen_rd;
		end
		if (hit(paddr, `DOUT_CTRL_IDX)) begin
			rd_nxt = dout_rd;
		end
		if (hit(paddr, `DIN_CTRL_IDX)) begin
			rd_nxt = din_rd;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= {24'h00_0000, rd_nxt};
		end
	end

	// ==========================================
	// general pin mux
	// reserved codes leave the pin off so a stray value cannot contend
	always @* begin
		multi_pin_five_o  = 1'b0;
		multi_pin_five_oe = 1'b1;
		case (gen_fn_r)
			`GEN_GP_OUT: begin
				multi_pin_five_o = gen_lvl_r;
			end
			`GEN_CLOCK_OUTPUT: begin
				multi_pin_five_o = clock_output;
			end
			`GEN_INT_A: begin
				multi_pin_five_o = interrupt_out_a;
			end
			`GEN_INT_B: begin
				multi_pin_five_o = interrupt_out_b;
			end
			`GEN_REC_WCLK: begin
				multi_pin_five_o = rec_word_clk;
			end
			`GEN_SEC_BCLK: begin
				multi_pin_five_o = sec_bit_clk;
			end
			`GEN_SEC_WCLK: begin
				multi_pin_five_o = sec_word_clk;
			end
			`GEN_DMIC_CLK: begin
				multi_pin_five_o = dmic_clk;
			end
			default: begin
				// off, input codes and the unused 1011..1111
				multi_pin_five_oe = 1'b0;
			end
		endcase
	end

	assign multi_pin_five_ie = gen_in_on(gen_fn_r);
	assign multi_pin_five_route = multi_pin_five_i && gen_is_route(gen_fn_r);

	// ==========================================
	// data-out pin mux
	always @* begin
		multi_pin_two_o  = 1'b0;
		multi_pin_two_oe = 1'b1;
		case (dout_fn_r)
			`DOUT_PRIMARY: begin
				multi_pin_two_o = primary_data_out;
			end
			`DOUT_GP_OUT: begin
				multi_pin_two_o = dout_lvl_r;
			end
			`DOUT_CLOCK_OUTPUT: begin
				multi_pin_two_o = clock_output;
			end
			`DOUT_INT_A: begin
				multi_pin_two_o = interrupt_out_a;
			end
			`DOUT_INT_B: begin
				multi_pin_two_o = interrupt_out_b;
			end
			`DOUT_SEC_BCLK: begin
				multi_pin_two_o = sec_bit_clk;
			end
			`DOUT_SEC_WCLK: begin
				multi_pin_two_o = sec_word_clk;
			end
			default: begin
				multi_pin_two_oe = 1'b0;
			end
		endcase
	end

	// keeper is enabled while the keep bit is clear, whether or not the pin is driven
	assign multi_pin_two_keep_en = !dout_keep_r;

	// ==========================================
	// data-in pin
	// code 11 is treated as off: the buffer stays closed
	assign multi_pin_one_ie = din_in_on(din_fn_r);
	assign multi_pin_one_route = multi_pin_one_i && din_is_route(din_fn_r);

endmodule // multifunction_pin_mux

// *** logic/pin_mux_consts.vh ***
// constants for the multifunction pin multiplexer
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// ==========================================
// register indices (byte address is four times the index)
`define RSVD_A_IDX      8'h32
`define RSVD_B_IDX      8'h33
`define GEN_CTRL_IDX    8'h34
`define DOUT_CTRL_IDX   8'h35
`define DIN_CTRL_IDX    8'h36
`define ADDR_LSB        2

// ==========================================
// general pin control fields
`define GEN_FN_HI       5
`define GEN_FN_LO       2
`define GEN_STAT_BIT    1
`define GEN_LVL_BIT     0
`define GEN_FN_RST      4'h0
`define GEN_LVL_RST     1'h0

// general pin function codes
`define GEN_OFF         4'h0
`define GEN_ROUTE_IN    4'h1
`define GEN_GP_IN       4'h2
`define GEN_GP_OUT      4'h3
`define GEN_CLOCK_OUTPUT      4'h4
`define GEN_INT_A       4'h5
`define GEN_INT_B       4'h6
`define GEN_REC_WCLK    4'h7
`define GEN_SEC_BCLK    4'h8
`define GEN_SEC_WCLK    4'h9
`define GEN_DMIC_CLK    4'ha

// ==========================================
// data-out pin control fields
`define DOUT_KEEP_BIT   4
`define DOUT_FN_HI      3
`define DOUT_FN_LO      1
`define DOUT_LVL_BIT    0
`define DOUT_KEEP_RST   1'h1
`define DOUT_FN_RST     3'h1
`define DOUT_LVL_RST    1'h0

// data-out pin function codes
`define DOUT_OFF        3'h0
`define DOUT_PRIMARY    3'h1
`define DOUT_GP_OUT     3'h2
`define DOUT_CLOCK_OUTPUT     3'h3
`define DOUT_INT_A      3'h4
`define DOUT_INT_B      3'h5
`define DOUT_SEC_BCLK   3'h6
`define DOUT_SEC_WCLK   3'h7

// ==========================================
// data-in pin control fields
`define DIN_FN_HI       2
`define DIN_FN_LO       1
`define DIN_STAT_BIT    0
`define DIN_FN_RST      2'h1

// data-in pin function codes
`define DIN_OFF         2'h0
`define DIN_ROUTE_IN    2'h1
`define DIN_GP_IN       2'h2

`endif

// *** sim/multifunction_pin_mux_props.sv ***
// assertions on the pin multiplexer ports
`timescale 1ns/1ps
// ==========================================
// checker
module multifunction_pin_mux_props (
	input wire logic        pclk, presetn, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic        clock_output, primary_data_out,
	input wire logic        multi_pin_five_o, multi_pin_five_oe, multi_pin_five_ie,
	input wire logic        multi_pin_two_o, multi_pin_two_oe, multi_pin_two_keep_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite;
	wire g_wr = wr && paddr == 12'h0d0;
	wire d_wr = wr && paddr == 12'h0d4;
	property p_rst; $rose(presetn) |-> multi_pin_two_oe && !multi_pin_five_oe
		&& !multi_pin_two_keep_en && multi_pin_two_o == primary_data_out; endproperty
	a_rst: assert property (p_rst) else $error("wrong pin state after reset");
	property p_goff; g_wr && pwdata[5:2] == 4'h0 |=> !multi_pin_five_oe && !multi_pin_five_ie;
	endproperty
	a_goff: assert property (p_goff) else $error("general pin not off");
	property p_gout; g_wr && pwdata[5:2] == 4'h3 |=> multi_pin_five_oe
		&& multi_pin_five_o == $past(pwdata[0]); endproperty
	a_gout: assert property (p_gout) else $error("general pin level wrong");
	property p_gclk; g_wr && pwdata[5:2] == 4'h4 |=> multi_pin_five_oe
		&& multi_pin_five_o == clock_output; endproperty
	a_gclk: assert property (p_gclk) else $error("general pin not clock");
	property p_doff; d_wr && pwdata[3:1] == 3'h0 |=> !multi_pin_two_oe; endproperty
	a_doff: assert property (p_doff) else $error("data-out pin not off");
	property p_dgp; d_wr && pwdata[3:1] == 3'h2 |=> multi_pin_two_oe
		&& multi_pin_two_o == $past(pwdata[0]); endproperty
	a_dgp: assert property (p_dgp) else $error("data-out level wrong");
	property p_keep; d_wr |=> multi_pin_two_keep_en == !$past(pwdata[4]); endproperty
	a_keep: assert property (p_keep) else $error("keeper enable wrong");
	property p_rsv; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("upper read bits set");
endmodule // multifunction_pin_mux_props
bind multifunction_pin_mux multifunction_pin_mux_props u_props (.*);

// *** sim/pin_far_side.sv ***
// board-side model of one multifunction pin
`timescale 1ns/1ps
// ==========================================
// pin wire
module pin_far_side (
	input  wire logic pclk,
	input  wire logic o,
	input  wire logic oe,
	input  wire logic drv_en,
	input  wire logic drv_val,
	output wire logic pin
);
	logic last_r = 1'h0;
	always @(posedge pclk) last_r <= pin;
	// an undriven pin has no pull: show a changing level, never a kind guess
	assign pin = oe ? o : (drv_en ? drv_val : ~last_r);
endmodule // pin_far_side

// *** sim/test_multifunction_pin_mux.sv ***
// self-checking bench for the multifunction pin multiplexer
`timescale 1ns/1ps
// ==========================================
// bench
module test_multifunction_pin_mux;
	typedef struct {logic [7:0] idx, wd; logic bd; logic [7:0] ex;} row_t;
	row_t rows [10] = '{'{8'h34, 8'h0d, 0, 8'h0d}, '{8'h34, 8'h08, 1, 8'h0a},
		'{8'h34, 8'h08, 0, 8'h08}, '{8'h35, 8'h05, 0, 8'h05}, '{8'h36, 8'h04, 1, 8'h05},
		'{8'h36, 8'h04, 0, 8'h04}, '{8'h36, 8'h00, 1, 8'h00},
		'{8'h36, 8'h02, 1, 8'h02}, '{8'h32, 8'h00, 1, 8'h00},
		'{8'h33, 8'h00, 1, 8'h00}};
	int dsel [8] = '{0, 7, 8, 0, 1, 2, 4, 5};
	logic [7:0] rx [5] = '{8'h00, 8'h00, 8'h00, 8'h12, 8'h02};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bd_en = 0, bd_val = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0]  src = 0;
	logic        pready, pslverr, er, f_o, f_oe, f_ie, t_o, t_oe, f_pin, o_pin, o_ie;
	logic        f_rt, o_rt;
	wire  [8:0]  ex = {1'h1, src};
	int          err_total = 0, n_checks = 0, cyc = 0;
	multifunction_pin_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clock_output(src[0]), .interrupt_out_a(src[1]),
		.interrupt_out_b(src[2]), .rec_word_clk(src[3]), .sec_bit_clk(src[4]),
		.sec_word_clk(src[5]), .dmic_clk(src[6]), .primary_data_out(src[7]),
		.multi_pin_five_i(f_pin), .multi_pin_five_o(f_o), .multi_pin_five_oe(f_oe),
		.multi_pin_five_ie(f_ie), .multi_pin_five_route(f_rt), .multi_pin_two_o(t_o),
		.multi_pin_two_oe(t_oe), .multi_pin_two_keep_en(), .multi_pin_one_i(o_pin),
		.multi_pin_one_ie(o_ie), .multi_pin_one_route(o_rt));
	pin_far_side five (.pclk(pclk), .o(f_o), .oe(f_oe), .drv_en(bd_en), .drv_val(bd_val),
		.pin(f_pin));
	pin_far_side one (.pclk(pclk), .o(1'h0), .oe(1'h0), .drv_en(bd_en), .drv_val(bd_val),
		.pin(o_pin));
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			conclude;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		// software writes reserved places only with their defaults
		foreach (rows[i]) begin
			{bd_en, bd_val} <= {1'h1, rows[i].bd};
			apb(1, {2'h0, rows[i].idx, 2'h0}, {24'h0, rows[i].wd});
			apb(0, {2'h0, rows[i].idx, 2'h0}, 0);
			chk("readback", rd, {24'h0, rows[i].ex});
		end
		bd_en <= 0;
		for (int c = 0; c < 19; c++) begin
			apb(1, c < 11 ? 12'h0d0 : 12'h0d4, c < 11 ? c * 4 + 1 : (c - 11) * 2 + 8'h11);
			for (int p = 0; p < 2; p++) begin
				@(posedge pclk);
				src <= p ? 8'h55 : 8'haa;
				@(negedge pclk);
				if (c < 11) begin
					chk("gen_oe", f_oe, c >= 3);
					chk("gen_ie", f_ie, c == 1 || c == 2);
					chk("gen_route", f_rt, c == 1 && f_pin);
					if (c >= 3) chk("gen_o", f_o, ex[c == 3 ? 8 : c - 4]);
				end else begin
					chk("dout_oe", t_oe, c != 11);
					if (c != 11) chk("dout_o", t_o, ex[dsel[c - 11]]);
				end
			end
		end
		apb(0, 12'h0dc, 0);
		chk("unmapped_err", er, 1);
		chk("unmapped_rd", rd, 0);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk("rst_din_ie", o_ie, 1);
		chk("rst_din_route", o_rt, o_pin);
		for (int k = 0; k < 5; k++) begin
			apb(0, 12'h0c8 + 4 * k, 0);
			chk("rst_value", rd, {24'h0, rx[k]});
		end
		conclude;
	end
endmodule // test_multifunction_pin_mux
